// ==== design/cci_consts.vh ====
// Offsets, field positions, reset values and timing of the comparator block
`ifndef CCI_CONSTS_VH
`define CCI_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CCI_OFF_CTRL1 5'h00
`define CCI_OFF_CTRL2 5'h04
`define CCI_OFF_AUX 5'h08
`define CCI_OFF_FLAG 5'h0C
`define CCI_OFF_IEN 5'h10
`define CCI_OFF_ICTL 5'h14
`define CCI_OFF_PORT 5'h18

// ****************************************************************
// Comparator control fields
// ****************************************************************
`define CCI_B_ON 7
`define CCI_B_OUT 6
`define CCI_B_OE 5
`define CCI_B_POL 4
`define CCI_B_REF 2
`define CCI_B_CH_HI 1
`define CCI_B_CH_LO 0

// ****************************************************************
// Auxiliary control fields
// ****************************************************************
`define CCI_B_MIR1 7
`define CCI_B_MIR2 6
`define CCI_B_RSEL1 5
`define CCI_B_RSEL2 4
`define CCI_B_GSS 1
`define CCI_B_SYNC 0

// ****************************************************************
// Interrupt and port fields
// ****************************************************************
`define CCI_B_GIE 7
`define CCI_B_PERIPHERAL_INT_ENABLE 6
`define CCI_B_DIR1 0
`define CCI_B_DIR2 1
`define CCI_B_LAT1 4
`define CCI_B_LAT2 5

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define CCI_RST_CTRL 8'h00
`define CCI_RST_AUX 8'h02
`define CCI_RST_FLAG 2'h0
`define CCI_RST_IEN 2'h0
`define CCI_RST_ICTL 2'h0
`define CCI_RST_DIR 2'h3
`define CCI_RST_LAT 2'h0
`define CCI_PHASES 4

`endif

// ==== design/cci_sync.v ====
// Three-stage synchroniser that accepts a level once stages two and three agree
module cci_sync (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire async_in,
    output reg sync_q
);

reg s1_q;
reg s2_q;
reg s3_q;

// ****************************************************************
// Stages
// ****************************************************************
always @(posedge clk) begin
    if (!resetn) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        sync_q <= 1'b0;
    end else if (ce) begin
        s1_q <= async_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
            sync_q <= s3_q;
        end
    end
end

endmodule // cci_sync

// ==== design/cci_channel.v ====
// One comparator channel: polarity, instruction-cycle latch and mismatch edge
module cci_channel (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire phase,
    input wire core_in,
    input wire enable,
    input wire invert,
    input wire capture,
    output reg live_q,
    output reg result_q,
    output wire mismatch_rise
);

reg capt_q;
reg mm_q;
wire mismatch;

// Capture latch against the instruction-cycle latch
assign mismatch = capt_q ^ result_q;
assign mismatch_rise = mismatch & ~mm_q;

// ****************************************************************
// Latches
// ****************************************************************
always @(posedge clk) begin
    if (!resetn) begin
        live_q <= 1'b0;
        result_q <= 1'b0;
        capt_q <= 1'b0;
        mm_q <= 1'b0;
    end else if (ce) begin
        live_q <= enable & (core_in ^ invert);
        if (phase) begin
            result_q <= live_q;
        end
        if (capture) begin
            capt_q <= result_q;
        end
        mm_q <= mismatch;
    end
end

endmodule // cci_channel

// ==== design/cci_top.v ====
// Control, status and change interrupt logic of two analog comparators
//
// Notes on behaviour
// - Comparator works only while enabled
// - Two-bit field picks inverting input pin
// - Reference bit picks non-inverting source
// - Result readable in control and aux registers
// - Pin shows result when enabled and output
// - Output enable overrides port latch, direction bit kept
// - Internal result latched each instruction cycle
// - Polarity bit inverts the comparison result
// - Control read captures first mismatch latch
// - Second latch on phase one, xor
// - Mismatch holds until read or return
// - Control write also clears mismatch
// - Interrupts independent of output enable
// - Flag set on mismatch rising edge
// - Software clears flag by 0, sets by 1
// - Request needs all three enables set
// - Only second comparator feeds timer gate
// - Reference one internal, zero input pin
// - Codes 00 to 11 pick pins 0-3
// - Aux register read leaves latches alone
// - Reset returns registers, comparators off
`include "cci_consts.vh"

module cci_top #(
    parameter PHASES = `CCI_PHASES
) (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire cmp1_core,
    input wire cmp2_core,
    output wire cmp1_enable,
    output wire cmp2_enable,
    output wire [1:0] cmp1_inv_sel,
    output wire [1:0] cmp2_inv_sel,
    output wire cmp1_ref_sel,
    output wire cmp2_ref_sel,
    output wire cmp1_vref_src,
    output wire cmp2_vref_src,
    output wire cmp1_pin_out,
    output wire cmp1_pin_oe_n,
    output wire cmp2_pin_out,
    output wire cmp2_pin_oe_n,
    output wire timer_gate_cmp,
    output wire timer_gate_sel,
    output wire timer_sync_en,
    output wire int_request
);

// ****************************************************************
// Helpers
// ****************************************************************
function hit;
    input [4:0] addr;
    input [4:0] off;
    begin
        hit = (addr == off);
    end
endfunction

function [7:0] ctrl_word;
    input [7:0] ctl;
    input res;
    begin
        ctrl_word = {ctl[`CCI_B_ON], res, ctl[`CCI_B_OE], ctl[`CCI_B_POL],
            1'b0, ctl[`CCI_B_REF], ctl[`CCI_B_CH_HI:`CCI_B_CH_LO]};
    end
endfunction

// ****************************************************************
// Declarations
// ****************************************************************
reg [7:0] ctrl1_q;
reg [7:0] ctrl2_q;
reg [5:0] aux_q;
reg [1:0] flag_q;
reg [1:0] ien_q;
reg [1:0] ictl_q;
reg [1:0] dir_q;
reg [1:0] lat_q;
reg wait_q;
reg [31:0] rdata_q;
reg [7:0] ph_q;
reg pin1_q;
reg pin1_oe_n_q;
reg pin2_q;
reg pin2_oe_n_q;
reg gate_q;
reg irq_q;
reg [7:0] rd_mux;
reg [1:0] flag_d;
wire [7:0] rst_aux;
wire phase;
wire acc;
wire wr_acc;
wire cap1;
wire cap2;
wire sync1;
wire sync2;
wire live1;
wire live2;
wire res1;
wire res2;
wire rise1;
wire rise2;
wire [7:0] wd;

assign wd = avs_writedata[7:0];
assign rst_aux = `CCI_RST_AUX;
assign phase = (ph_q == 8'h00);

// Completing edge of a bus access
assign acc = (avs_read | avs_write) & ~wait_q;
assign wr_acc = acc & avs_write & avs_byteenable[0];

// Any access to a control register reads it first
assign cap1 = acc & hit(avs_address, `CCI_OFF_CTRL1);
assign cap2 = acc & hit(avs_address, `CCI_OFF_CTRL2);

// ****************************************************************
// Instruction-cycle phase counter
// ****************************************************************
always @(posedge clk) begin
    if (!resetn) begin
        ph_q <= 8'h00;
    end else if (ce) begin
        if (ph_q == PHASES[7:0] - 8'h01) begin
            ph_q <= 8'h00;
        end else begin
            ph_q <= ph_q + 8'h01;
        end
    end
end

// ****************************************************************
// Comparator channels
// ****************************************************************
cci_sync u_sync1 (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .async_in(cmp1_core),
    .sync_q(sync1)
);

cci_sync u_sync2 (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .async_in(cmp2_core),
    .sync_q(sync2)
);

cci_channel u_ch1 (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .phase(phase),
    .core_in(sync1),
    .enable(ctrl1_q[`CCI_B_ON]),
    .invert(ctrl1_q[`CCI_B_POL]),
    .capture(cap1),
    .live_q(live1),
    .result_q(res1),
    .mismatch_rise(rise1)
);

cci_channel u_ch2 (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .phase(phase),
    .core_in(sync2),
    .enable(ctrl2_q[`CCI_B_ON]),
    .invert(ctrl2_q[`CCI_B_POL]),
    .capture(cap2),
    .live_q(live2),
    .result_q(res2),
    .mismatch_rise(rise2)
);

// ****************************************************************
// Bus handshake
// ****************************************************************
always @(posedge clk) begin
    if (!resetn) begin
        wait_q <= 1'b1;
        rdata_q <= 32'h0000_0000;
    end else if (ce) begin
        if (!wait_q) begin
            wait_q <= 1'b1;
        end else if (avs_read | avs_write) begin
            wait_q <= 1'b0;
            if (avs_read) begin
                rdata_q <= {24'h00_0000, rd_mux};
            end
        end
    end
end

// ****************************************************************
// Read multiplexer
// ****************************************************************
always @* begin
    rd_mux = 8'h00;
    case (avs_address)
        `CCI_OFF_CTRL1: begin
            rd_mux = ctrl_word(ctrl1_q, res1);
        end
        `CCI_OFF_CTRL2: begin
            rd_mux = ctrl_word(ctrl2_q, res2);
        end
        `CCI_OFF_AUX: begin
            rd_mux = {res1, res2, aux_q};
        end
        `CCI_OFF_FLAG: begin
            rd_mux = {6'h00, flag_q};
        end
        `CCI_OFF_IEN: begin
            rd_mux = {6'h00, ien_q};
        end
        `CCI_OFF_ICTL: begin
            rd_mux = {ictl_q, 6'h00};
        end
        `CCI_OFF_PORT: begin
            rd_mux = {2'h0, lat_q, 2'h0, dir_q};
        end
        default: begin
            rd_mux = 8'h00;
        end
    endcase
end

// ****************************************************************
// Control registers
// ****************************************************************
always @(posedge clk) begin
    if (!resetn) begin
        ctrl1_q <= `CCI_RST_CTRL;
        ctrl2_q <= `CCI_RST_CTRL;
        aux_q <= rst_aux[5:0];
    end else if (ce && wr_acc) begin
        if (hit(avs_address, `CCI_OFF_CTRL1)) begin
            ctrl1_q <= wd & 8'hB7;
        end
        if (hit(avs_address, `CCI_OFF_CTRL2)) begin
            ctrl2_q <= wd & 8'hB7;
        end
        if (hit(avs_address, `CCI_OFF_AUX)) begin
            aux_q <= {wd[5:4], 2'h0, wd[1:0]};
        end
    end
end

// ****************************************************************
// Interrupt enables and port settings
// ****************************************************************
always @(posedge clk) begin
    if (!resetn) begin
        ien_q <= `CCI_RST_IEN;
        ictl_q <= `CCI_RST_ICTL;
        dir_q <= `CCI_RST_DIR;
        lat_q <= `CCI_RST_LAT;
    end else if (ce && wr_acc) begin
        if (hit(avs_address, `CCI_OFF_IEN)) begin
            ien_q <= wd[1:0];
        end
        if (hit(avs_address, `CCI_OFF_ICTL)) begin
            ictl_q <= {wd[`CCI_B_GIE], wd[`CCI_B_PERIPHERAL_INT_ENABLE]};
        end
        if (hit(avs_address, `CCI_OFF_PORT)) begin
            dir_q <= {wd[`CCI_B_DIR2], wd[`CCI_B_DIR1]};
            lat_q <= {wd[`CCI_B_LAT2], wd[`CCI_B_LAT1]};
        end
    end
end

// ****************************************************************
// Change flags
// ****************************************************************
always @* begin
    flag_d = flag_q;
    if (wr_acc && hit(avs_address, `CCI_OFF_FLAG)) begin
        flag_d = wd[1:0];
    end
    flag_d = flag_d | {rise2, rise1};
end

always @(posedge clk) begin
    if (!resetn) begin
        flag_q <= `CCI_RST_FLAG;
        irq_q <= 1'b0;
    end else if (ce) begin
        flag_q <= flag_d;
        irq_q <= (|(flag_q & ien_q)) & ictl_q[1] & ictl_q[0];
    end
end

// ****************************************************************
// Output pins and timer link
// ****************************************************************
always @(posedge clk) begin
    if (!resetn) begin
        pin1_q <= 1'b0;
        pin2_q <= 1'b0;
        pin1_oe_n_q <= 1'b1;
        pin2_oe_n_q <= 1'b1;
        gate_q <= 1'b0;
    end else if (ce) begin
        // Live result drives the pin, not the cycle latch
        if (ctrl1_q[`CCI_B_OE]) begin
            pin1_q <= live1;
        end else begin
            pin1_q <= lat_q[0];
        end
        if (ctrl2_q[`CCI_B_OE]) begin
            pin2_q <= live2;
        end else begin
            pin2_q <= lat_q[1];
        end
        pin1_oe_n_q <= dir_q[0];
        pin2_oe_n_q <= dir_q[1];
        gate_q <= live2;
    end
end

// ****************************************************************
// Outputs
// ****************************************************************
assign avs_readdata = rdata_q;
assign avs_waitrequest = wait_q;
assign cmp1_enable = ctrl1_q[`CCI_B_ON];
assign cmp2_enable = ctrl2_q[`CCI_B_ON];
assign cmp1_inv_sel = ctrl1_q[`CCI_B_CH_HI:`CCI_B_CH_LO];
assign cmp2_inv_sel = ctrl2_q[`CCI_B_CH_HI:`CCI_B_CH_LO];
assign cmp1_ref_sel = ctrl1_q[`CCI_B_REF];
assign cmp2_ref_sel = ctrl2_q[`CCI_B_REF];
assign cmp1_vref_src = aux_q[`CCI_B_RSEL1];
assign cmp2_vref_src = aux_q[`CCI_B_RSEL2];
assign cmp1_pin_out = pin1_q;
assign cmp1_pin_oe_n = pin1_oe_n_q;
assign cmp2_pin_out = pin2_q;
assign cmp2_pin_oe_n = pin2_oe_n_q;
assign timer_gate_cmp = gate_q;
assign timer_gate_sel = aux_q[`CCI_B_GSS];
assign timer_sync_en = aux_q[`CCI_B_SYNC];
assign int_request = irq_q;

endmodule // cci_top

// ==== sim/cci_core_mdl.sv ====
// Behavioural analog comparator core and its input pins
module cci_core_mdl (
    input logic clk,
    input logic en,
    input logic ref_sel,
    input logic [1:0] inv_sel,
    input logic [7:0] vref,
    input logic [7:0] vpos,
    input logic [31:0] vneg,
    output logic core
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk_q = 1'b0;
    logic [7:0] vp;
    logic [7:0] vn;
    // Unpowered core gives no valid level
    always @(posedge clk) junk_q <= ~junk_q;
    assign vp = ref_sel ? vref : vpos;
    assign vn = vneg[inv_sel*8 +: 8];
    assign core = en ? (vp > vn) : junk_q;
endmodule // cci_core_mdl

// ==== sim/cci_top_chk.sv ====
// Checker of bus, reset and control outputs
module cci_top_chk (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire cmp1_enable,
    input wire cmp2_enable,
    input wire [1:0] cmp1_inv_sel,
    input wire cmp2_ref_sel,
    input wire cmp1_pin_oe_n,
    input wire cmp2_pin_oe_n,
    input wire timer_gate_cmp,
    input wire timer_gate_sel,
    input wire int_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wait_pulse_a:
    assert property (!avs_waitrequest && ce |=> avs_waitrequest)
        else $error("waitrequest low too long");
    wait_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest && ce
        |=> !avs_waitrequest) else $error("request not answered");
    rd_upper_a:
    assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    reset_vals_a:
    assert property ($rose(resetn) |-> !cmp1_enable && !cmp2_enable
        && cmp1_pin_oe_n && cmp2_pin_oe_n && timer_gate_sel && !int_request)
        else $error("bad value after reset");
    gate_off_a:
    assert property (!cmp2_enable [*3] |-> !timer_gate_cmp)
        else $error("timer gate high while disabled");
    sel_write_a:
    assert property ($changed(cmp1_inv_sel) |-> $past(avs_write
        && !avs_waitrequest && avs_address == 5'h00))
        else $error("select changed without write");
    en_write_a:
    assert property ($changed(cmp2_enable) |-> $past(avs_write
        && !avs_waitrequest && avs_address == 5'h04))
        else $error("enable changed without write");
    ref_write_a:
    assert property ($changed(cmp2_ref_sel) |-> $past(avs_write
        && !avs_waitrequest && avs_address == 5'h04))
        else $error("reference changed without write");
endmodule // cci_top_chk

bind cci_top cci_top_chk i_cci_top_chk (.clk(clk), .resetn(resetn),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmp1_enable(cmp1_enable),
    .cmp2_enable(cmp2_enable), .cmp1_inv_sel(cmp1_inv_sel),
    .cmp2_ref_sel(cmp2_ref_sel), .cmp1_pin_oe_n(cmp1_pin_oe_n),
    .cmp2_pin_oe_n(cmp2_pin_oe_n), .timer_gate_cmp(timer_gate_cmp),
    .timer_gate_sel(timer_gate_sel), .int_request(int_request));

// ==== sim/cci_top_tb.sv ====
// Self-checking bench of the comparator block
module cci_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PH = 2;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [7:0] vref = 8'h00, vp1 = 8'h28, vp2 = 8'h00;
    logic [31:0] vneg = 32'h4030_2010;
    logic [31:0] rd;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    wire [31:0] rdat;
    wire wait_r, c1, c2, en1, en2, rs1, rs2, o1, oe1, o2, oe2, gate, irq;
    wire [1:0] s1, s2;
    wire vr1, vr2, gsel, gsync;
    wire [31:0] pinv = {27'h000_0000, gate, oe2, o2, oe1, o1};
    cci_top #(.PHASES(PH)) i_cci_top (.clk(clk), .resetn(resetn), .ce(1'b1),
        .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
        .avs_writedata(wdat), .avs_byteenable(4'h1), .avs_readdata(rdat),
        .avs_waitrequest(wait_r), .cmp1_core(c1), .cmp2_core(c2),
        .cmp1_enable(en1), .cmp2_enable(en2), .cmp1_inv_sel(s1),
        .cmp2_inv_sel(s2), .cmp1_ref_sel(rs1), .cmp2_ref_sel(rs2),
        .cmp1_vref_src(vr1), .cmp2_vref_src(vr2), .cmp1_pin_out(o1),
        .cmp1_pin_oe_n(oe1), .cmp2_pin_out(o2), .cmp2_pin_oe_n(oe2),
        .timer_gate_cmp(gate), .timer_gate_sel(gsel), .timer_sync_en(gsync),
        .int_request(irq));
    cci_core_mdl i_core1 (.clk(clk), .en(en1), .ref_sel(rs1), .inv_sel(s1),
        .vref(vref), .vpos(vp1), .vneg(vneg), .core(c1));
    cci_core_mdl i_core2 (.clk(clk), .en(en2), .ref_sel(rs2), .inv_sel(s2),
        .vref(vref), .vpos(vp2), .vneg(vneg), .core(c2));
    // ****
    // Clock, timeout and bus tasks
    // ****
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        adr <= a;
        wdat <= {24'h00_0000, d};
        wr_en <= 1'b1;
        @(posedge clk);
        while (wait_r) @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdr(input logic [4:0] a, input logic [31:0] exp);
        adr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        while (wait_r) @(posedge clk);
        rd = rdat;
        rd_en <= 1'b0;
        @(posedge clk);
        chk(rd, exp);
    endtask
    task automatic settle;
        repeat (8 * PH) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        rdr(5'h00, 32'h0000_0000);
        rdr(5'h08, 32'h0000_0002);
        rdr(5'h1C, 32'h0000_0000);
        chk(pinv, 32'h0000_000A);
        chk({28'h000_0000, vr1, vr2, gsel, gsync}, 32'h0000_0002);
        $display("Reset test done");
    endtask
    task automatic t_select;
        logic [7:0] c;
        logic r;
        for (int i = 0; i < 8; i++) begin
            c = {3'h4, i[2], 2'h0, i[1:0]};
            wr(5'h00, c);
            settle();
            r = (vp1 > vneg[i[1:0]*8 +: 8]) ^ i[2];
            rdr(5'h00, {24'h00_0000, c | {1'b0, r, 6'h00}});
        end
        vref <= 8'hFF;
        wr(5'h00, 8'h87);
        settle();
        rdr(5'h08, 32'h0000_0082);
        $display("Select test done");
    endtask
    task automatic t_irq;
        wr(5'h00, 8'h83);
        settle();
        rdr(5'h00, 32'h0000_0083);
        wr(5'h0C, 8'h00);
        wr(5'h10, 8'h01);
        wr(5'h14, 8'hC0);
        vp1 <= 8'h50;
        settle();
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rdr(5'h0C, 32'h0000_0001);
        wr(5'h0C, 8'h00);
        settle();
        rdr(5'h0C, 32'h0000_0000);
        rdr(5'h08, 32'h0000_0082);
        vp1 <= 8'h28;
        settle();
        rdr(5'h0C, 32'h0000_0000);
        vp1 <= 8'h50;
        wr(5'h14, 8'h80);
        settle();
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rdr(5'h0C, 32'h0000_0001);
        wr(5'h00, 8'h83);
        wr(5'h0C, 8'h00);
        vp1 <= 8'h28;
        settle();
        rdr(5'h0C, 32'h0000_0001);
        wr(5'h14, 8'hC0);
        wr(5'h10, 8'h02);
        wr(5'h0C, 8'h02);
        settle();
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rdr(5'h0C, 32'h0000_0002);
        wr(5'h0C, 8'h00);
        $display("Interrupt test done");
    endtask
    task automatic t_pins;
        wr(5'h18, 8'h10);
        settle();
        chk(pinv, 32'h0000_0001);
        wr(5'h00, 8'hA3);
        settle();
        chk(pinv, 32'h0000_0000);
        vp1 <= 8'h50;
        settle();
        chk(pinv, 32'h0000_0001);
        wr(5'h00, 8'h23);
        wr(5'h18, 8'h13);
        settle();
        chk(pinv, 32'h0000_000A);
        wr(5'h04, 8'h84);
        settle();
        chk(pinv, 32'h0000_001A);
        rdr(5'h08, 32'h0000_0042);
        vref <= 8'h00;
        settle();
        chk(pinv, 32'h0000_000A);
        wr(5'h08, 8'h21);
        rdr(5'h08, 32'h0000_0021);
        chk({28'h000_0000, vr1, vr2, gsel, gsync}, 32'h0000_0009);
        $display("Pin test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_select();
        t_irq();
        t_pins();
        end_of_test();
    end
endmodule // cci_top_tb
